// >>> floppy_drive_control_regs.sv
// Drive control and status registers of the floppy controller
`timescale 1ns/1ps
`include "fdc_drive_ctrl_defines.svh"

// Functional notes
// R1: Enhanced bit 1 mirrors motor-1 output
// R2: Enhanced bit 2 shows live write gate
// R3: Enhanced bits 3,4 toggle on data edges
// R4: Enhanced bit 5 reflects drive-select bit 0
// R5: Enhanced bits 6,7 always read one
// R6: Alternate bits 0,1 unsupported, read one; bit 7 shows second-drive sense
// R7: Alternate bit 2 latches write gate rise
// R8: Alternate bit 3 latches read-data trailing edge
// R9: Alternate bit 4 latches write-data trailing edge
// R10: Alternate bits 5,6 show active-low selects
// R11: Output register zero on hardware reset only
// R12: Bits 1:0 binary drive number, one select
// R13: Bit 2 low holds controller in reset
// R14: Back-to-back clear/set writes give valid reset
// R15: Bit 3 gates DMA and interrupt pins
// R16: Enhanced mode keeps pins enabled, clears bit
// R17: Bits 4,5 drive motor outputs 0,1
// R18: Host writes 1C or 2D to start drive
// R19: Tape register bits 1:0 pick tape drive
// R20: Tape bits 7:2 undriven, software reset ignored
// R21: Normal decode of selects and motors
// R22: Swapped decode exchanges drives 0 and 1
// R23: Legacy mode status read leaves bus undriven
// R24: Mode and swap come from stable inputs
// R25: Drive signals synchronised before edge detection
module floppy_drive_control_regs (
	// Clock and hardware reset
	input  wire logic                             clk_sys,
	input  wire logic                             reset,
	// Configuration straps
	input  wire fdc_drive_ctrl_pkg::status_mode_e status_mode,
	input  wire logic                             swap_drives,
	// Host I/O bus
	input  wire logic [15:0]                      io_addr,
	input  wire logic                             io_rd,
	input  wire logic                             io_wr,
	input  wire logic [7:0]                       io_wdata,
	output logic      [7:0]                       io_rdata,
	output logic      [7:0]                       io_rdata_oe,
	// Drive interface inputs and observed outputs
	input  wire logic                             read_data_n,
	input  wire logic                             write_data_n,
	input  wire logic                             write_gate,
	input  wire logic                             second_drive_present_n,
	// Drive interface outputs
	output logic                                  drive_sel_0_n,
	output logic                                  drive_sel_1_n,
	output logic                                  motor_on_0_n,
	output logic                                  motor_on_1_n,
	// Controller control
	output logic                                  ctrl_reset,
	output logic                                  dma_irq_pins_en
);

	localparam logic [7:0] RESET_CYC = 8'(`SOFT_RST_CYCLES);

	logic [7:0] digital_output;          // Host control register
	logic [1:0] tape_drive_assign;       // Tape drive number
	logic       tog_rd;                  // Read data toggle
	logic       tog_wr;                  // Write data toggle
	logic       lat_wg;                  // Latched write gate
	logic       lat_rd;                  // Latched read data
	logic       lat_wr;                  // Latched write data
	logic [7:0] next_digital_output;
	logic [1:0] next_tape_drive_assign;
	logic       next_tog_rd;
	logic       next_tog_wr;
	logic       next_lat_wg;
	logic       next_lat_rd;
	logic       next_lat_wr;
	logic [7:0] next_io_rdata;
	logic [7:0] next_io_rdata_oe;
	logic       dsel0_n_c;
	logic       dsel1_n_c;
	logic       mot0_n_c;
	logic       mot1_n_c;
	logic       wg_level;
	logic       wg_rise;
	logic       rd_rise;
	logic       wr_rise;
	logic       drv2_level;
	logic       is_enh;
	logic       is_alt;
	logic       dir_read;
	logic [7:0] status_val;
	logic [7:0] rst_cnt;                 // Remaining stretch of the soft reset
	logic [7:0] next_rst_cnt;
	logic       next_ctrl_reset;
	logic       next_pins_en;

	// Drive pins are asynchronous to the bus clock: sync then edge-detect
	sync_edge u_sync_wg (  // R25
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in (write_gate),
		.level    (wg_level),
		.rise     (wg_rise),
		.fall     ()
	);
	sync_edge u_sync_rd (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in (read_data_n),
		.level    (),
		.rise     (rd_rise),
		.fall     ()
	);
	sync_edge u_sync_wr (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in (write_data_n),
		.level    (),
		.rise     (wr_rise),
		.fall     ()
	);
	sync_edge u_sync_drv2 (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in (second_drive_present_n),
		.level    (drv2_level),
		.rise     (),
		.fall     ()
	);

	// Drive select and motor decode
	drive_decode u_decode (
		.drive_num     (digital_output[`DOUT_DRV_HI:`DOUT_DRV_LO]),  // R12
		.motor_bit_0   (digital_output[`DOUT_MOT0]),  // R17
		.motor_bit_1   (digital_output[`DOUT_MOT1]),  // R17
		.swap_drives   (swap_drives),  // R24
		.drive_sel_0_n (dsel0_n_c),
		.drive_sel_1_n (dsel1_n_c),
		.motor_on_0_n  (mot0_n_c),
		.motor_on_1_n  (mot1_n_c)
	);

	// Mode decode; straps are assumed static while running
	assign is_enh   = (status_mode == fdc_drive_ctrl_pkg::enhanced_status_mode);  // R24
	assign is_alt   = (status_mode == fdc_drive_ctrl_pkg::alternate_status_mode);  // R24
	assign dir_read = io_rd & (io_addr == `ADDR_DIGITAL_INPUT);

	// Status register image; reads the registered pin levels
	always_comb begin
		status_val = 8'h00;
		if (is_alt) begin
			status_val[0] = 1'b1;  // R6
			status_val[1] = 1'b1;  // R6
			status_val[2] = lat_wg;  // R7
			status_val[3] = lat_rd;  // R8
			status_val[4] = lat_wr;  // R9
			status_val[5] = drive_sel_0_n;  // R10
			status_val[6] = drive_sel_1_n;  // R10
			status_val[7] = drv2_level;  // R6
		end else begin
			status_val[0] = ~motor_on_0_n;
			status_val[1] = ~motor_on_1_n;  // R1
			status_val[2] = wg_level;  // R2
			status_val[3] = tog_rd;  // R3
			status_val[4] = tog_wr;  // R3
			status_val[5] = digital_output[`DOUT_DRV_LO];  // R4
			status_val[6] = 1'b1;  // R5
			status_val[7] = 1'b1;  // R5
		end
	end

	// Next values for registers, status flops and read data
	always_comb begin
		next_digital_output    = digital_output;
		next_tape_drive_assign = tape_drive_assign;
		next_tog_rd            = tog_rd ^ rd_rise;  // R3
		next_tog_wr            = tog_wr ^ wr_rise;  // R3
		// Latched bits: a set in the clearing cycle wins
		next_lat_wg = wg_rise | (lat_wg & ~dir_read);  // R7
		next_lat_rd = rd_rise | (lat_rd & ~dir_read);  // R8
		next_lat_wr = wr_rise | (lat_wr & ~dir_read);  // R9
		next_io_rdata    = 8'h00;
		next_io_rdata_oe = 8'h00;
		// Stretch the controller reset: a clear/set write pair still spans 100 ns
		if (!digital_output[`DOUT_SOFT_RST]) begin
			next_rst_cnt = RESET_CYC - 8'h01;  // R14
		end else if (rst_cnt != 8'h00) begin
			next_rst_cnt = rst_cnt - 8'h01;  // R14
		end else begin
			next_rst_cnt = 8'h00;
		end
		next_ctrl_reset = !digital_output[`DOUT_SOFT_RST] || (rst_cnt != 8'h00);  // R13 R14
		next_pins_en    = is_enh | digital_output[`DOUT_DMA_EN];  // R15 R16
		// Writes accepted at any time, even during soft reset
		if (io_wr && io_addr == `ADDR_DIGITAL_OUTPUT) begin
			next_digital_output = io_wdata;  // R11
		end else if (io_wr && io_addr == `ADDR_TAPE_DRIVE) begin
			next_tape_drive_assign = io_wdata[1:0];  // R19
		end
		// Enhanced mode forces the enable bit clear during soft reset
		if (is_enh && !next_digital_output[`DOUT_SOFT_RST]) begin
			next_digital_output[`DOUT_DMA_EN] = 1'b0;  // R16
		end
		// Read decode; legacy status read and unmapped leave bus undriven
		if (io_rd && io_addr == `ADDR_DRIVE_STATUS_B) begin
			if (!(is_enh || is_alt)) begin
				next_io_rdata_oe = 8'h00;  // R23
			end else begin
				next_io_rdata    = status_val;
				next_io_rdata_oe = 8'hFF;
			end
		end else if (io_rd && io_addr == `ADDR_DIGITAL_OUTPUT) begin
			next_io_rdata    = digital_output;
			next_io_rdata_oe = 8'hFF;
		end else if (io_rd && io_addr == `ADDR_TAPE_DRIVE) begin
			next_io_rdata    = {6'h00, tape_drive_assign};
			next_io_rdata_oe = 8'h03;  // R20
		end
	end

	// Hardware reset only; soft reset never reaches these flops
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			digital_output    <= `DOUT_RESET_VAL;  // R11
			tape_drive_assign <= `TAPE_RESET_VAL;  // R20
			tog_rd            <= 1'b0;
			tog_wr            <= 1'b0;
			lat_wg            <= 1'b0;
			lat_rd            <= 1'b0;
			lat_wr            <= 1'b0;
			io_rdata          <= 8'h00;
			io_rdata_oe       <= 8'h00;
			drive_sel_0_n     <= 1'b1;
			drive_sel_1_n     <= 1'b1;
			motor_on_0_n      <= 1'b1;
			motor_on_1_n      <= 1'b1;
			ctrl_reset        <= 1'b1;
			rst_cnt           <= 8'h00;
		end else begin
			digital_output    <= next_digital_output;
			tape_drive_assign <= next_tape_drive_assign;
			tog_rd            <= next_tog_rd;
			tog_wr            <= next_tog_wr;
			lat_wg            <= next_lat_wg;
			lat_rd            <= next_lat_rd;
			lat_wr            <= next_lat_wr;
			io_rdata          <= next_io_rdata;
			io_rdata_oe       <= next_io_rdata_oe;
			drive_sel_0_n     <= dsel0_n_c;
			drive_sel_1_n     <= dsel1_n_c;
			motor_on_0_n      <= mot0_n_c;
			motor_on_1_n      <= mot1_n_c;
			rst_cnt           <= next_rst_cnt;
			ctrl_reset        <= next_ctrl_reset;  // R13
		end
	end

	// Pin enable skips hardware reset so enhanced mode keeps the pins live
	always_ff @(posedge clk_sys) begin
		dma_irq_pins_en <= next_pins_en;  // R16
	end

	// Assertions
	a_reset_follows: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(digital_output[`DOUT_SOFT_RST]) |=> ctrl_reset)  // R13
		else $error("controller reset did not follow cleared bit");
	a_pulse_width: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(ctrl_reset) |-> ctrl_reset[*5])  // R14
		else $error("software reset pulse shorter than minimum");
	a_pins_enh: assert property (@(posedge clk_sys) disable iff (reset)
		$past(is_enh) |-> dma_irq_pins_en)  // R16
		else $error("pins disabled in enhanced mode");
	a_pins_gate: assert property (@(posedge clk_sys) disable iff (reset)
		!$past(is_enh) |-> dma_irq_pins_en == $past(digital_output[`DOUT_DMA_EN]))  // R15
		else $error("pin enable does not follow enable bit");
	a_one_select: assert property (@(posedge clk_sys) disable iff (reset)
		!(drive_sel_0_n == 1'b0 && drive_sel_1_n == 1'b0))  // R12
		else $error("two drive selects active");
	a_motor_map: assert property (@(posedge clk_sys) disable iff (reset)
		!$past(swap_drives) |-> motor_on_0_n == ~$past(digital_output[`DOUT_MOT0]))  // R21
		else $error("motor 0 output wrong in normal decode");
	sequence s_wg_edge;
		wg_rise && !dir_read;
	endsequence
	a_wg_latch: assert property (@(posedge clk_sys) disable iff (reset)
		s_wg_edge ##1 !dir_read[*2] |=> lat_wg)  // R7
		else $error("write gate latch lost");
	a_dir_clear: assert property (@(posedge clk_sys) disable iff (reset)
		dir_read && !rd_rise |=> !lat_rd)  // R8
		else $error("read data latch not cleared by input read");
	a_toggle_rd: assert property (@(posedge clk_sys) disable iff (reset)
		rd_rise |=> tog_rd != $past(tog_rd))  // R3
		else $error("read toggle did not change");
	a_legacy_quiet: assert property (@(posedge clk_sys) disable iff (reset)
		io_rd && io_addr == `ADDR_DRIVE_STATUS_B && !is_enh && !is_alt
		|=> io_rdata_oe == 8'h00)  // R23
		else $error("bus driven on legacy status read");
	a_tape_hiz: assert property (@(posedge clk_sys) disable iff (reset)
		io_rd && io_addr == `ADDR_TAPE_DRIVE |=> io_rdata_oe == 8'h03)  // R20
		else $error("upper tape bits driven");
	a_stretch_tail: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(digital_output[`DOUT_SOFT_RST]) |=> ctrl_reset[*4])  // R14
		else $error("soft reset released before its minimum width");
	a_enh_clear: assert property (@(posedge clk_sys) disable iff (reset)
		is_enh && $past(is_enh) && !digital_output[`DOUT_SOFT_RST] |-> !digital_output[`DOUT_DMA_EN])  // R16
		else $error("enable bit kept during enhanced soft reset");

endmodule

// >>> fdc_drive_ctrl_defines.svh
// Register offsets, field positions and reset values for the drive control registers
`ifndef FDC_DRIVE_CTRL_DEFINES_SVH
`define FDC_DRIVE_CTRL_DEFINES_SVH

// Host I/O addresses (primary base)
`define ADDR_DRIVE_STATUS_B   16'h03F1
`define ADDR_DIGITAL_OUTPUT   16'h03F2
`define ADDR_TAPE_DRIVE       16'h03F3
`define ADDR_DIGITAL_INPUT    16'h03F7

// Digital output register fields
`define DOUT_RESET_VAL        8'h00
`define DOUT_DRV_LO           0
`define DOUT_DRV_HI           1
`define DOUT_SOFT_RST         2
`define DOUT_DMA_EN           3
`define DOUT_MOT0             4
`define DOUT_MOT1             5

// Tape register reset value and implemented width
`define TAPE_RESET_VAL        2'h0

// Software reset pulse time and its cycle count at 50 MHz
`define SOFT_RST_MIN_NS       100
`define CLK_PERIOD_NS         20
`define SOFT_RST_CYCLES       ((`SOFT_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> fdc_drive_ctrl_pkg.sv
// Types shared by the drive control register bank
package fdc_drive_ctrl_pkg;

	// Status presentation modes
	typedef enum logic [1:0] {
		legacy_mode,
		enhanced_status_mode,
		alternate_status_mode
	} status_mode_e;

endpackage

// >>> sync_edge.sv
// Two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ps

module sync_edge (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// Asynchronous level in
	input  wire logic async_in,
	// Synchronised level and edge pulses
	output logic      level,
	output logic      rise,
	output logic      fall
);

	logic stage_a;      // First flop, read only by stage_b
	logic stage_b;      // Second flop, safe to use
	logic stage_c;      // Delayed copy for edge detection
	logic next_stage_a;
	logic next_stage_b;
	logic next_stage_c;
	logic [2:0] fill;   // Marks which flops hold real pin data since reset
	logic [2:0] next_fill;

	// Next values of the shift chain
	always_comb begin
		next_stage_a = async_in;
		next_stage_b = stage_a;
		next_stage_c = stage_b;
		next_fill    = {fill[1:0], 1'b1};
	end

	// Register the chain; reset to idle low
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stage_a <= 1'b0;
			stage_b <= 1'b0;
			stage_c <= 1'b0;
			fill    <= 3'h0;
		end else begin
			stage_a <= next_stage_a;
			stage_b <= next_stage_b;
			stage_c <= next_stage_c;
			fill    <= next_fill;
		end
	end

	// Edges come from the settled flops only; held off until the chain is
	// refilled, else a pin idling high would give a false edge after reset
	assign level = stage_b;
	assign rise  = fill[2] & stage_b & ~stage_c;
	assign fall  = fill[2] & ~stage_b & stage_c;

endmodule

// >>> drive_decode.sv
// Two-drive select and motor decode, normal or swapped
`timescale 1ns/1ps

module drive_decode (
	// Control bits from the digital output register
	input  wire logic [1:0] drive_num,
	input  wire logic       motor_bit_0,
	input  wire logic       motor_bit_1,
	input  wire logic       swap_drives,
	// Active-low drive outputs
	output logic            drive_sel_0_n,
	output logic            drive_sel_1_n,
	output logic            motor_on_0_n,
	output logic            motor_on_1_n
);

	logic sel_a;  // Logical drive 0 selected with its motor on
	logic sel_b;  // Logical drive 1 selected with its motor on

	// Decode drive number against the matching motor bit
	always_comb begin
		sel_a = (drive_num == 2'b00) & motor_bit_0;  // R21
		sel_b = (drive_num == 2'b01) & motor_bit_1;  // R21
		if (swap_drives) begin
			// Swapped wiring exchanges drives 0 and 1
			drive_sel_0_n = ~sel_b;  // R22
			drive_sel_1_n = ~sel_a;  // R22
			motor_on_0_n  = ~motor_bit_1;  // R22
			motor_on_1_n  = ~motor_bit_0;  // R22
		end else begin
			drive_sel_0_n = ~sel_a;  // R21
			drive_sel_1_n = ~sel_b;  // R21
			motor_on_0_n  = ~motor_bit_0;  // R21
			motor_on_1_n  = ~motor_bit_1;  // R21
		end
	end

endmodule

// >>> drive_model.sv
// Floppy drive model that drives the drive-side status inputs
`timescale 1ns/1ps

module drive_model (
	// Clock used only to time the pulses and level changes
	input  wire logic clk_sys,
	// Lines from the drive toward the controller
	output logic      read_data_n,
	output logic      write_data_n,
	output logic      write_gate,
	output logic      second_drive_present_n
);
	// Idle: data lines high, gate off, second drive absent (pulled up)
	initial begin
		read_data_n = 1'b1;
		write_data_n = 1'b1;
		write_gate = 1'b0;
		second_drive_present_n = 1'b1;
	end

	// Two-clock low pulse on one data line, then time for the synchroniser
	task automatic pulse(input logic on_write);
		@(negedge clk_sys);
		if (on_write) begin
			write_data_n = 1'b0;
		end else begin
			read_data_n = 1'b0;
		end
		repeat (2) @(negedge clk_sys);
		write_data_n = 1'b1;
		read_data_n = 1'b1;
		repeat (5) @(negedge clk_sys);
	endtask

	// Gate level change, held long enough to be seen
	task automatic gate(input logic on);
		@(negedge clk_sys);
		write_gate = on;
		repeat (5) @(negedge clk_sys);
	endtask

	// Second-drive sense level, held long enough to be seen
	task automatic set_present(input logic present_n);
		@(negedge clk_sys);
		second_drive_present_n = present_n;
		repeat (5) @(negedge clk_sys);
	endtask
endmodule

// >>> tb_floppy_drive_control_regs.sv
// Self-checking bench for the drive control register bank
`timescale 1ns/1ps

module tb_floppy_drive_control_regs;
	// Clock, reset and straps
	logic                             clk_sys = 1'b0;
	logic                             reset;
	fdc_drive_ctrl_pkg::status_mode_e status_mode;
	logic                             swap_drives;
	// Host bus
	logic [15:0] io_addr;
	logic        io_rd;
	logic        io_wr;
	logic [7:0]  io_wdata;
	logic [7:0]  io_rdata;
	logic [7:0]  io_rdata_oe;
	// Drive side
	logic        read_data_n;
	logic        write_data_n;
	logic        write_gate;
	logic        second_drive_present_n;
	logic        drive_sel_0_n;
	logic        drive_sel_1_n;
	logic        motor_on_0_n;
	logic        motor_on_1_n;
	logic        ctrl_reset;
	logic        dma_irq_pins_en;
	// Tallies
	int          num_errors = 0;
	int          n_checks = 0;

	always #10 clk_sys = ~clk_sys;

	floppy_drive_control_regs dut (.clk_sys(clk_sys), .reset(reset),
		.status_mode(status_mode), .swap_drives(swap_drives), .io_addr(io_addr),
		.io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.io_rdata_oe(io_rdata_oe), .read_data_n(read_data_n),
		.write_data_n(write_data_n), .write_gate(write_gate),
		.second_drive_present_n(second_drive_present_n),
		.drive_sel_0_n(drive_sel_0_n), .drive_sel_1_n(drive_sel_1_n),
		.motor_on_0_n(motor_on_0_n), .motor_on_1_n(motor_on_1_n),
		.ctrl_reset(ctrl_reset), .dma_irq_pins_en(dma_irq_pins_en));

	drive_model drive (.clk_sys(clk_sys), .read_data_n(read_data_n),
		.write_data_n(write_data_n), .write_gate(write_gate),
		.second_drive_present_n(second_drive_present_n));

	// Compare and tally
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and stop
	task end_of_test;
		if (num_errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Expected pins {sel1_n, sel0_n, mot1_n, mot0_n}, worked out independently
	function automatic logic [3:0] dec(input logic [7:0] d, input logic sw);
		logic a0;
		logic a1;
		a0 = (d[1:0] == 2'b00) && d[4];
		a1 = (d[1:0] == 2'b01) && d[5];
		if (sw) begin
			return {~a0, ~a1, ~d[4], ~d[5]};
		end
		return {~a1, ~a0, ~d[5], ~d[4]};
	endfunction

	// One-cycle write strobe; leaves two extra cycles so pins have landed
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clk_sys);
		io_wr = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask

	// One-cycle read strobe; data stands in the following cycle
	task strobe(input logic [15:0] a);
		@(negedge clk_sys);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clk_sys);
		io_rd = 1'b0;
	endtask

	// Read and compare only the bits that are expected to be driven
	task rd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] oe);
		strobe(a);
		chk(io_rdata_oe, oe);
		chk(io_rdata & oe, d & oe);
	endtask

	task pins(input logic [3:0] e);
		chk({4'h0, drive_sel_1_n, drive_sel_0_n, motor_on_1_n, motor_on_0_n}, {4'h0, e});
	endtask

	// Hardware reset long enough for the synchronisers to clear
	task hw_reset;
		@(negedge clk_sys);
		reset = 1'b1;
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		// Let the pin synchronisers refill before the first request
		repeat (3) @(negedge clk_sys);
	endtask

	task t_reset;
		pins(4'hF);
		chk({7'h0, ctrl_reset}, 8'h01);
		chk({7'h0, dma_irq_pins_en}, 8'h00);
		rd(16'h03F2, 8'h00, 8'hFF);
		rd(16'h03F1, 8'h00, 8'h00);
		rd(16'h03F3, 8'h00, 8'h03);
		rd(16'h03F0, 8'h00, 8'h00);
	endtask

	// Every table row in normal and swapped decode
	task t_decode;
		logic [7:0] tbl [7];
		tbl = '{8'h1C, 8'h2D, 8'h3E, 8'h3F, 8'h0C, 8'h15, 8'hC6};
		for (int s = 0; s < 2; s++) begin
			swap_drives = s[0];
			foreach (tbl[i]) begin
				wr(16'h03F2, tbl[i]);
				pins(dec(tbl[i], s[0]));
				chk({7'h0, dma_irq_pins_en}, {7'h0, tbl[i][3]});
				rd(16'h03F2, tbl[i], 8'hFF);
			end
		end
		swap_drives = 1'b0;
	endtask

	task t_tape;
		for (int t = 0; t < 4; t++) begin
			wr(16'h03F3, 8'hFC | 8'(t));
			rd(16'h03F3, 8'(t), 8'h03);
		end
	endtask

	// Back-to-back clear/set of the reset bit, then a held soft reset
	task t_soft;
		wr(16'h03F2, 8'h1C);
		@(negedge clk_sys);
		io_addr = 16'h03F2;
		io_wdata = 8'h18;
		io_wr = 1'b1;
		@(negedge clk_sys);
		io_wdata = 8'h1C;
		@(negedge clk_sys);
		io_wr = 1'b0;
		chk({7'h0, ctrl_reset}, 8'h01);
		repeat (4) @(negedge clk_sys);
		chk({7'h0, ctrl_reset}, 8'h01);
		@(negedge clk_sys);
		chk({7'h0, ctrl_reset}, 8'h00);
		rd(16'h03F2, 8'h1C, 8'hFF);
		pins(dec(8'h1C, 1'b0));
		wr(16'h03F2, 8'h31);
		chk({7'h0, ctrl_reset}, 8'h01);
		rd(16'h03F2, 8'h31, 8'hFF);
		rd(16'h03F3, 8'h03, 8'h03);
		wr(16'h03F2, 8'h1C);
		chk({7'h0, ctrl_reset}, 8'h01);
		repeat (3) @(negedge clk_sys);
		chk({7'h0, ctrl_reset}, 8'h00);
	endtask

	task t_enh;
		status_mode = fdc_drive_ctrl_pkg::enhanced_status_mode;
		hw_reset();
		rd(16'h03F1, 8'hC0, 8'hFF);
		wr(16'h03F2, 8'h08);
		chk({7'h0, dma_irq_pins_en}, 8'h01);
		rd(16'h03F2, 8'h00, 8'hFF);
		wr(16'h03F2, 8'h2D);
		rd(16'h03F1, 8'hE2, 8'hFF);
		drive.gate(1'b1);
		rd(16'h03F1, 8'hE6, 8'hFF);
		drive.pulse(1'b0);
		rd(16'h03F1, 8'hEE, 8'hFF);
		drive.pulse(1'b1);
		rd(16'h03F1, 8'hFE, 8'hFF);
		drive.pulse(1'b0);
		rd(16'h03F1, 8'hF6, 8'hFF);
		drive.gate(1'b0);
		rd(16'h03F1, 8'hF2, 8'hFF);
	endtask

	task t_alt;
		status_mode = fdc_drive_ctrl_pkg::alternate_status_mode;
		hw_reset();
		rd(16'h03F1, 8'hE3, 8'hFF);
		wr(16'h03F2, 8'h1C);
		chk({7'h0, dma_irq_pins_en}, 8'h01);
		rd(16'h03F1, 8'hC3, 8'hFF);
		drive.gate(1'b1);
		drive.gate(1'b0);
		rd(16'h03F1, 8'hC7, 8'hFF);
		strobe(16'h03F7);
		rd(16'h03F1, 8'hC3, 8'hFF);
		drive.pulse(1'b0);
		rd(16'h03F1, 8'hCB, 8'hFF);
		drive.pulse(1'b1);
		rd(16'h03F1, 8'hDB, 8'hFF);
		strobe(16'h03F7);
		rd(16'h03F1, 8'hC3, 8'hFF);
		drive.set_present(1'b0);
		rd(16'h03F1, 8'h43, 8'hFF);
		drive.set_present(1'b1);
	endtask

	// Main sequence
	initial begin
		reset = 1'b1;
		status_mode = fdc_drive_ctrl_pkg::legacy_mode;
		swap_drives = 1'b0;
		io_addr = 16'h0000;
		io_rd = 1'b0;
		io_wr = 1'b0;
		io_wdata = 8'h00;
		repeat (10) @(negedge clk_sys);
		reset = 1'b0;
		@(negedge clk_sys);
		t_reset();
		t_decode();
		t_tape();
		t_soft();
		t_enh();
		t_alt();
		end_of_test();
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200_000;
		num_errors++;
		end_of_test();
	end
endmodule
